// >>> rtl/timer_chan_consts.svh
// register indices, field positions and reset values of the timer channel status block
`ifndef TIMER_CHAN_CONSTS_SVH
`define TIMER_CHAN_CONSTS_SVH
`define IDX_C0_IE 22'h0F0274
`define IDX_C0_POL 22'h0F0275
`define IDX_C1_FLAGS 22'h0F0283
`define IDX_C1_IE 22'h0F0284
`define IDX_C1_POL 22'h0F0285
`define IDX_C1_CTRL 22'h0F0290
`define RST_BYTE 8'h00
`define RST_CTRL 12'h000
`define FLAG_OVF 4
`define FLAG_UDF 5
`define IE_WRAP 4
`define FLAG_MASK 8'h3F
`define IE_MASK 8'h1F
`define POL_MASK 8'h07
`define CTRL_MASK 12'hF3F
`define CTRL_FUNC 1:0
`define CTRL_EDGE_A 3:2
`define CTRL_EDGE_B 5:4
`define CTRL_XFER 11:8
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define CNT_MAX 16'hFFFF
`define CNT_ZERO 16'h0000
`endif

// >>> rtl/timer_chan_pkg.sv
// types shared by the timer channel status block
package timer_chan_pkg;
  typedef enum logic [1:0] {FUNC_CAPTURE, FUNC_COMPARE, FUNC_PWM, FUNC_COMP_PWM} func_e;
  typedef enum logic [2:0] {SEL_C0_IE, SEL_C0_POL, SEL_FLAGS, SEL_IE, SEL_POL, SEL_CTRL,
    SEL_NONE} reg_sel_e;
  typedef struct packed {
    logic [15:0] count;
    logic [3:0][15:0] gen;
  } timer_in_s;
  typedef struct packed {
    logic [7:0] c0Ie;
    logic [7:0] c0Pol;
    logic [7:0] flags;
    logic [7:0] ie;
    logic [7:0] pol;
    logic [7:0] seen;
    logic [11:0] ctrl;
    logic [15:0] cntPrev;
    logic [3:0] eqPrev;
    logic [3:0] pend;
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic stA;
    logic stB;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irqReq;
    logic xferReq;
    logic [2:0] pwmPin;
  } state_s;
endpackage

// >>> rtl/timer_channel_status_irq.sv
// status flags, interrupt enables and pwm polarity of timer channel one
//
// Contract
// - writing 1 leaves a flag unchanged
// - write 0 keeps flag last read 0
// - write 0 clears flag last read 1
// - counter wrap FFFFH to 0000H sets overflow; here not in complementary pwm, where a wrap leaves overflow clear
// - wrap caused by match clear sets overflow
// - underflow sets flag, complementary pwm only
// - counter equal general register sets match flag
// - flags C, D also in buffer mode
// - capture edges on pins A, B set flags
// - capture edge chosen by two-bit select
// - routed events set flag after transfer completes
// - wrap enable gates overflow and underflow interrupt
// - per-flag enables gate match interrupts
// - polarity applies only in pwm function
// - polarity 0 makes pin active low
// - all registers reset to 00H
// - polarity 1 makes pin active high
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`include "timer_chan_consts.svh"

module timer_channel_status_irq (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [23:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire timer_chan_pkg::timer_in_s timerIn,
  input wire logic capPinA,
  input wire logic capPinB,
  input wire logic xferDone,
  input wire logic [2:0] pwmLevel,
  output logic [2:0] pwmPin,
  output logic irqReq,
  output logic xferReq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // word index to register select
  function automatic timer_chan_pkg::reg_sel_e decodeSel(input logic [23:0] addr);
    case (addr[23:2])
      `IDX_C0_IE: decodeSel = timer_chan_pkg::SEL_C0_IE;
      `IDX_C0_POL: decodeSel = timer_chan_pkg::SEL_C0_POL;
      `IDX_C1_FLAGS: decodeSel = timer_chan_pkg::SEL_FLAGS;
      `IDX_C1_IE: decodeSel = timer_chan_pkg::SEL_IE;
      `IDX_C1_POL: decodeSel = timer_chan_pkg::SEL_POL;
      `IDX_C1_CTRL: decodeSel = timer_chan_pkg::SEL_CTRL;
      default: decodeSel = timer_chan_pkg::SEL_NONE;
    endcase
  endfunction

  // does a settled level change match the chosen capture edge
  function automatic logic edgeHit(input logic [1:0] edgeSel, input logic newLvl);
    case (edgeSel)
      `EDGE_RISE: edgeHit = newLvl;
      `EDGE_FALL: edgeHit = ~newLvl;
      default: edgeHit = 1'b1; // both edges
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  timer_chan_pkg::state_s q;
  timer_chan_pkg::state_s n;
  timer_chan_pkg::func_e func;
  timer_chan_pkg::reg_sel_e sel;
  logic setupPh;
  logic accessPh;
  logic wrAcc;
  logic rdAcc;
  logic wrFlags;
  logic [3:0] eqNow;
  logic [3:0] rawEv;
  logic [3:0] routed;
  logic [3:0] doneSet;
  logic capA;
  logic capB;
  logic ovfEv;
  logic udfEv;
  logic [7:0] setEv;
  logic [7:0] clrEv;
  logic [31:0] rdMux;

  // bus phase decode
  assign setupPh = psel & ~penable;
  assign accessPh = psel & penable & q.pready;
  assign wrAcc = accessPh & pwrite;
  assign rdAcc = accessPh & ~pwrite;
  assign sel = decodeSel(paddr);
  assign wrFlags = wrAcc & (sel == timer_chan_pkg::SEL_FLAGS);
  assign func = timer_chan_pkg::func_e'(q.ctrl[`CTRL_FUNC]);

  // equality of counter with each general register
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_eq
      assign eqNow[gi] = (timerIn.count == timerIn.gen[gi]);
    end
  endgenerate

  // settled pin change meeting the selected edge
  assign capA = (q.syncA[1] == q.syncA[2]) && (q.syncA[2] != q.stA)
    && edgeHit(q.ctrl[`CTRL_EDGE_A], q.syncA[2]);
  assign capB = (q.syncB[1] == q.syncB[2]) && (q.syncB[2] != q.stB)
    && edgeHit(q.ctrl[`CTRL_EDGE_B], q.syncB[2]);

  ////////////////////////////////////////////////////////////////////////////
  // event sources

  // capture pins in capture function, counter equality otherwise
  always_comb begin
    if (func == timer_chan_pkg::FUNC_CAPTURE) begin
      rawEv = {2'b00, capB, capA};
    end else begin
      rawEv = eqNow & ~q.eqPrev;
    end
  end

  // routed events wait for the transfer controller
  assign routed = rawEv & q.ctrl[`CTRL_XFER];
  assign doneSet = xferDone ? q.pend : 4'h0;

  // wrap and underflow of the counter
  assign ovfEv = (func != timer_chan_pkg::FUNC_COMP_PWM) && (q.cntPrev == `CNT_MAX)
    && (timerIn.count == `CNT_ZERO);
  assign udfEv = (func == timer_chan_pkg::FUNC_COMP_PWM) && (q.cntPrev == `CNT_ZERO)
    && (timerIn.count == `CNT_MAX);

  assign setEv = {2'b00, udfEv, ovfEv, (rawEv & ~q.ctrl[`CTRL_XFER]) | doneSet};

  // only flags last read as 1 and written 0 are cleared
  assign clrEv = wrFlags ? (q.seen & ~pwdata[7:0]) : 8'h00;

  // read data for the setup cycle
  always_comb begin
    rdMux = 32'h0000_0000;
    case (sel)
      timer_chan_pkg::SEL_C0_IE: rdMux[7:0] = q.c0Ie;
      timer_chan_pkg::SEL_C0_POL: rdMux[7:0] = q.c0Pol;
      timer_chan_pkg::SEL_FLAGS: rdMux[7:0] = q.flags;
      timer_chan_pkg::SEL_IE: rdMux[7:0] = q.ie;
      timer_chan_pkg::SEL_POL: rdMux[7:0] = q.pol;
      timer_chan_pkg::SEL_CTRL: rdMux[11:0] = q.ctrl;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = q;
    // apb answer is ready in the first access cycle
    n.pready = setupPh;
    n.pslverr = setupPh && (sel == timer_chan_pkg::SEL_NONE);
    n.prdata = setupPh ? rdMux : 32'h0000_0000;
    // register writes
    if (wrAcc) begin
      case (sel)
        timer_chan_pkg::SEL_C0_IE: n.c0Ie = pwdata[7:0] & `IE_MASK;
        timer_chan_pkg::SEL_C0_POL: n.c0Pol = pwdata[7:0] & `POL_MASK;
        timer_chan_pkg::SEL_IE: n.ie = pwdata[7:0] & `IE_MASK;
        timer_chan_pkg::SEL_POL: n.pol = pwdata[7:0] & `POL_MASK;
        timer_chan_pkg::SEL_CTRL: n.ctrl = pwdata[11:0] & `CTRL_MASK;
        default: n.ctrl = q.ctrl;
      endcase
    end
    // flags: a set in the clear cycle wins
    n.flags = ((q.flags & ~clrEv) | setEv) & `FLAG_MASK;
    if (rdAcc && (sel == timer_chan_pkg::SEL_FLAGS)) begin
      n.seen = q.prdata[7:0];
    end else begin
      n.seen = q.seen & ~clrEv;
    end
    // counter history and transfer bookkeeping
    n.cntPrev = timerIn.count;
    n.eqPrev = eqNow;
    n.pend = (q.pend & ~doneSet) | routed;
    n.xferReq = |n.pend;
    // three-stage pin synchronisers, settled level kept when stages agree
    n.syncA = {q.syncA[1:0], capPinA};
    n.syncB = {q.syncB[1:0], capPinB};
    if (q.syncA[1] == q.syncA[2]) begin
      n.stA = q.syncA[2];
    end
    if (q.syncB[1] == q.syncB[2]) begin
      n.stB = q.syncB[2];
    end
    // interrupt request from enabled flags
    n.irqReq = (|(q.flags[3:0] & q.ie[3:0]))
      | ((q.flags[`FLAG_OVF] | q.flags[`FLAG_UDF]) & q.ie[`IE_WRAP]);
    // polarity only in pwm function
    if (func == timer_chan_pkg::FUNC_PWM) begin
      n.pwmPin = ~(pwmLevel ^ q.pol[2:0]);
    end else begin
      n.pwmPin = pwmLevel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // outputs straight from state
  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign irqReq = q.irqReq;
  assign xferReq = q.xferReq;
  assign pwmPin = q.pwmPin;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  write_one_keep_a: assert property (
    wrFlags |=> ((($past(q.flags) & $past(pwdata[7:0])) & ~q.flags) == 8'h00))
    else $error("flag cleared by writing 1");

  seen_zero_keep_a: assert property (
    wrFlags |=> ((($past(q.flags) & ~$past(q.seen)) & ~q.flags) == 8'h00))
    else $error("flag not read as 1 was cleared");

  seen_one_clear_a: assert property (
    wrFlags |=> (($past(q.seen) & ~$past(pwdata[7:0]) & ~$past(setEv) & q.flags) == 8'h00))
    else $error("flag read as 1 not cleared by 0");

  wrap_sets_ovf_a: assert property (
    (func != timer_chan_pkg::FUNC_COMP_PWM) && (timerIn.count == `CNT_MAX)
    ##1 (timerIn.count == `CNT_ZERO) |=> q.flags[`FLAG_OVF])
    else $error("wrap did not set overflow");

  udf_idle_a: assert property (
    (func != timer_chan_pkg::FUNC_COMP_PWM) && !q.flags[`FLAG_UDF] |=> !q.flags[`FLAG_UDF])
    else $error("underflow set outside complementary pwm");

  xfer_before_flag_a: assert property (
    $rose(q.flags[0]) && $past(q.ctrl[8]) |-> $past(xferDone))
    else $error("routed flag set before transfer done");

  irq_follows_a: assert property (
    (|(q.flags[3:0] & q.ie[3:0])) ##1 (|(q.flags[3:0] & q.ie[3:0])) |-> irqReq)
    else $error("enabled flag gave no interrupt");

  wrap_gate_a: assert property (
    !q.ie[`IE_WRAP] && ((q.flags[3:0] & q.ie[3:0]) == 4'h0) |=> !irqReq)
    else $error("interrupt without enabled source");

  pol_ignored_a: assert property (
    (func != timer_chan_pkg::FUNC_PWM) |=> (pwmPin == $past(pwmLevel)))
    else $error("polarity applied outside pwm");

  pol_low_a: assert property (
    (func == timer_chan_pkg::FUNC_PWM) && !q.pol[0] |=> (pwmPin[0] == !$past(pwmLevel[0])))
    else $error("polarity 0 not active low");

  pol_high_a: assert property (
    (func == timer_chan_pkg::FUNC_PWM) && q.pol[1] |=> (pwmPin[1] == $past(pwmLevel[1])))
    else $error("polarity 1 not active high");

  ////////////////////////////////////////////////////////////////////////////
  // further checks on flag setting, gating, polarity and the bus answer

  // wrap seen through the stored previous count
  wrap_prev_ovf_a: assert property (
    (func != timer_chan_pkg::FUNC_COMP_PWM) && (q.cntPrev == `CNT_MAX)
    && (timerIn.count == `CNT_ZERO) |=> q.flags[`FLAG_OVF])
    else $error("wrap from previous count did not set overflow");

  // direct match a sets its flag one edge later
  match_a_set_a: assert property (
    (func != timer_chan_pkg::FUNC_CAPTURE) && (timerIn.count == timerIn.gen[0])
    && !q.eqPrev[0] && !q.ctrl[8] |=> q.flags[0])
    else $error("match a did not set its flag");

  // match b sets its flag one edge later
  match_b_set_a: assert property (
    (func != timer_chan_pkg::FUNC_CAPTURE) && (timerIn.count == timerIn.gen[1])
    && !q.eqPrev[1] && !q.ctrl[9] |=> q.flags[1])
    else $error("match b did not set its flag");

  // c still sets on equality when used as a buffer
  match_c_set_a: assert property (
    (func != timer_chan_pkg::FUNC_CAPTURE) && (timerIn.count == timerIn.gen[2])
    && !q.eqPrev[2] && !q.ctrl[10] |=> q.flags[2])
    else $error("match c did not set its flag");

  // d still sets on equality when used as a buffer
  match_d_set_a: assert property (
    (func != timer_chan_pkg::FUNC_CAPTURE) && (timerIn.count == timerIn.gen[3])
    && !q.eqPrev[3] && !q.ctrl[11] |=> q.flags[3])
    else $error("match d did not set its flag");

  // capture on pin a sets flag a
  capture_a_set_a: assert property (
    (func == timer_chan_pkg::FUNC_CAPTURE) && capA && !q.ctrl[8] |=> q.flags[0])
    else $error("capture a did not set its flag");

  // capture on pin b sets flag b
  capture_b_set_a: assert property (
    (func == timer_chan_pkg::FUNC_CAPTURE) && capB && !q.ctrl[9] |=> q.flags[1])
    else $error("capture b did not set its flag");

  // rising select only reacts to a settled high level
  edge_rise_a: assert property (
    (q.ctrl[`CTRL_EDGE_A] == `EDGE_RISE) && capA |-> q.syncA[2])
    else $error("rising select took a falling edge");

  // falling select only reacts to a settled low level
  edge_fall_a: assert property (
    (q.ctrl[`CTRL_EDGE_B] == `EDGE_FALL) && capB |-> !q.syncB[2])
    else $error("falling select took a rising edge");

  // a routed event waits as pending work
  routed_pend_a: assert property (
    rawEv[0] && q.ctrl[8] |=> q.pend[0])
    else $error("routed event not held pending");

  // all enables off keeps the request low
  all_gated_a: assert property (
    (q.ie == 8'h00) |=> !irqReq)
    else $error("interrupt with every enable off");

  // an enabled match c raises the request
  match_irq_a: assert property (
    q.flags[2] && q.ie[2] |=> irqReq)
    else $error("enabled match c gave no interrupt");

  // an enabled underflow raises the request
  udf_irq_a: assert property (
    q.flags[`FLAG_UDF] && q.ie[`IE_WRAP] |=> irqReq)
    else $error("enabled underflow gave no interrupt");

  // polarity 0 on output d gives active low
  pol_low_d_a: assert property (
    (func == timer_chan_pkg::FUNC_PWM) && !q.pol[2] |=> (pwmPin[2] == !$past(pwmLevel[2])))
    else $error("polarity 0 on d not active low");

  // polarity 1 on output b gives active high
  pol_high_b_a: assert property (
    (func == timer_chan_pkg::FUNC_PWM) && q.pol[0] |=> (pwmPin[0] == $past(pwmLevel[0])))
    else $error("polarity 1 on b not active high");

  // the bus answer comes in the first access cycle
  ready_in_access_a: assert property (
    psel && !penable |=> pready)
    else $error("no ready in first access cycle");

  // an unmapped address is answered with an error
  unmapped_err_a: assert property (
    psel && !penable && (sel == timer_chan_pkg::SEL_NONE) |=> pslverr)
    else $error("unmapped address gave no error");

  // the two top flag bits never set
  reserved_flags_a: assert property (
    q.flags[7:6] == 2'b00)
    else $error("reserved flag bit set");

endmodule // timer_channel_status_irq

// >>> bench/timer_channel_status_irq_tb_top.sv
// self-checking bench for the timer channel status, enable and polarity block
`timescale 1ns/100ps
`include "timer_chan_consts.svh"

module timer_channel_status_irq_tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [23:0] paddr = 24'h000000;
  logic [31:0] pwdata = 32'h00000000;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  timer_chan_pkg::timer_in_s timerIn;
  logic capPinA = 1'b0;
  logic capPinB = 1'b0;
  logic xferDone = 1'b0;
  logic [2:0] pwmLevel = 3'h0;
  logic [2:0] pwmPin;
  logic irqReq;
  logic xferReq;
  logic [31:0] rd;
  logic er;
  logic [2:0] pol;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  integer seed = 32'h3854;

  timer_channel_status_irq timer_channel_status_irq_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .timerIn(timerIn),
    .capPinA(capPinA), .capPinB(capPinB), .xferDone(xferDone), .pwmLevel(pwmLevel),
    .pwmPin(pwmPin), .irqReq(irqReq), .xferReq(xferReq));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #10 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compares, bus cycles and expectations
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: register got %h want %h", $time, g, e);
    end
  endtask

  task chkPin(input logic [2:0] g, input logic [2:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: pin got %h want %h", $time, g, e);
    end
  endtask

  // apb transfer held until pready is sampled high or 20 access cycles pass
  task rw(input logic w, input logic [21:0] i, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [21:0] i, input logic [7:0] e);
    rw(1'b0, i, 32'h00000000);
    chk(rd, {24'h000000, e});
  endtask

  task cnt(input logic [15:0] v);
    @(posedge ref_clk);
    timerIn.count <= v;
  endtask

  task wt(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // read then write zero: clears every flag that was read as set
  task clr;
    rw(1'b0, `IDX_C1_FLAGS, 32'h00000000);
    rw(1'b1, `IDX_C1_FLAGS, 32'h00000000);
  endtask

  function automatic logic [2:0] expPin(input logic [1:0] f, input logic [2:0] l,
    input logic [2:0] p);
    return (f == timer_chan_pkg::FUNC_PWM) ? ~(l ^ p) : l;
  endfunction

  task close_out;
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    timerIn.count = 16'h8000;
    for (int i = 0; i < 4; i++) timerIn.gen[i] = {4'(i + 1), 12'($random(seed))};
    wt(20);
    arst_n <= 1'b1;
    rdc(`IDX_C0_IE, 8'h00);
    rdc(`IDX_C0_POL, 8'h00);
    rdc(`IDX_C1_FLAGS, 8'h00);
    rdc(`IDX_C1_IE, 8'h00);
    rdc(`IDX_C1_POL, 8'h00);
    rw(1'b0, 22'h0F0300, 32'h00000000);
    chkPin({2'b00, er}, 3'h1);
    rw(1'b1, `IDX_C0_IE, 32'hFFFFFFFF);
    rdc(`IDX_C0_IE, `IE_MASK);
    // compare function: each match and one wrap, underflow must stay clear
    rw(1'b1, `IDX_C1_CTRL, 32'h00000001);
    for (int i = 0; i < 4; i++) begin
      cnt(timerIn.gen[i]);
      cnt(16'h8000);
    end
    cnt(`CNT_MAX);
    cnt(`CNT_ZERO);
    cnt(`CNT_MAX);
    cnt(16'h8000);
    wt(3);
    chkPin({2'b00, irqReq}, 3'h0);
    rdc(`IDX_C1_FLAGS, 8'h1F);
    rw(1'b1, `IDX_C1_FLAGS, 32'h0000003F);
    rdc(`IDX_C1_FLAGS, 8'h1F);
    rw(1'b1, `IDX_C1_FLAGS, 32'h00000000);
    rdc(`IDX_C1_FLAGS, 8'h00);
    cnt(timerIn.gen[0]);
    cnt(16'h8000);
    wt(3);
    rw(1'b1, `IDX_C1_FLAGS, 32'h00000000);
    rdc(`IDX_C1_FLAGS, 8'h01);
    rw(1'b1, `IDX_C1_IE, 32'h00000012);
    wt(3);
    chkPin({2'b00, irqReq}, 3'h0);
    rw(1'b1, `IDX_C1_IE, 32'h00000001);
    wt(3);
    chkPin({2'b00, irqReq}, 3'h1);
    clr();
    wt(3);
    chkPin({2'b00, irqReq}, 3'h0);
    // complementary pwm: underflow sets, wrap does not
    rw(1'b1, `IDX_C1_IE, 32'h00000010);
    rw(1'b1, `IDX_C1_CTRL, 32'h00000003);
    cnt(`CNT_ZERO);
    cnt(`CNT_MAX);
    cnt(`CNT_ZERO);
    cnt(16'h8000);
    wt(3);
    chkPin({2'b00, irqReq}, 3'h1);
    rdc(`IDX_C1_FLAGS, 8'h20);
    rw(1'b1, `IDX_C1_IE, 32'h00000000);
    clr();
    // polarity in every function with random levels
    for (int k = 0; k < 8; k++) begin
      pol = 3'($random(seed));
      rw(1'b1, `IDX_C1_CTRL, {30'h0, 2'(k)});
      rw(1'b1, `IDX_C1_POL, {24'h0, 5'($random(seed)), pol});
      @(posedge ref_clk);
      pwmLevel <= 3'($random(seed));
      wt(3);
      chkPin(pwmPin, expPin(2'(k), pwmLevel, pol));
    end
    // capture: edge a rising, edge b falling
    rw(1'b1, `IDX_C1_CTRL, 32'h00000010);
    @(posedge ref_clk);
    capPinA <= 1'b1;
    capPinB <= 1'b1;
    wt(8);
    rdc(`IDX_C1_FLAGS, 8'h01);
    clr();
    capPinA <= 1'b0;
    capPinB <= 1'b0;
    wt(8);
    rdc(`IDX_C1_FLAGS, 8'h02);
    clr();
    // match a routed to the transfer controller
    rw(1'b1, `IDX_C1_CTRL, 32'h00000101);
    cnt(timerIn.gen[0]);
    cnt(16'h8000);
    wt(3);
    chkPin({2'b00, xferReq}, 3'h1);
    rdc(`IDX_C1_FLAGS, 8'h00);
    @(posedge ref_clk);
    xferDone <= 1'b1;
    @(posedge ref_clk);
    xferDone <= 1'b0;
    wt(3);
    rdc(`IDX_C1_FLAGS, 8'h01);
    // reset in mid-run
    @(posedge ref_clk);
    arst_n <= 1'b0;
    wt(2);
    arst_n <= 1'b1;
    rdc(`IDX_C1_IE, 8'h00);
    rdc(`IDX_C1_FLAGS, 8'h00);
    close_out();
  end
endmodule // timer_channel_status_irq_tb_top
